// ==== hdl/apb_regs.sv ====
// APB write-strobe and read-mux helper for the capture channel.
// Assumes zero-wait APB; pready is high only in the access cycle after setup.
module apb_regs import capture_pkg::*; (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] ctl_q,
  input wire logic [31:0] mode_q,
  input wire logic [31:0] stat_q,
  input wire logic [31:0] cnt_q,
  input wire logic [31:0] cap_q,
  input wire logic [31:0] en_q,
  output logic wr,
  output logic [31:0] rdata,
  output logic err
);
  always_comb begin
    wr = psel & penable & pwrite;
    err = 1'b0;
    case (paddr)
      addr_control: rdata = ctl_q;
      addr_mode: rdata = mode_q;
      addr_trigger: rdata = 32'h0000_0000;
      addr_status: rdata = stat_q;
      addr_counter: rdata = cnt_q;
      addr_capture: rdata = cap_q;
      addr_enable: rdata = en_q;
      default: begin
        rdata = 32'h0000_0000;
        err = 1'b1;
      end
    endcase
  end
endmodule // apb_regs

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser and edge detector for the timer input pin.
// Assumes the pin is asynchronous to pclk.
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic pin,
  edge_if.src e
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t r_r, r_nxt;
  always_comb begin
    r_nxt = r_r;
    if (clr) begin
      r_nxt = '0;
    end else if (ce) begin
      r_nxt.s1 = pin;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_r <= '0;
    else r_r <= r_nxt;
  end
  // Edges only from the second stage onward
  assign e.level = r_r.s2;
  assign e.rise = ce & r_r.s2 & ~r_r.s3;
  assign e.fall = ce & ~r_r.s2 & r_r.s3;
endmodule // pin_sync

// ==== hdl/pulse_capture.sv ====
// Input pulse width / interval capture channel with APB registers.
// Assumes APB master on pclk; timer_input_pin is asynchronous.
// Summary of operation
// - Interval: capture, clear counter, interrupt per edge
// - Interval: overflow flag per capture
// - Stop trigger clears enable, self-clears
// - Stop keeps counter and overflow flag
// - Power-enable low resets all registers
// - Width mode counter counts up
// - Start sets enable, waits start edge
// - Start edge: count from zero
// - Capture edge: store, interrupt, overflow flag
// - Counter halts at capture plus one
// - Multiple wraps still one overflow flag
// - Edge select 10 low, 11 high
// - High width: rise starts, fall captures
// - Start ignored while enabled in width mode
// - Pin sampled on clock, one cycle error
// - Width equals overflow*10000H plus capture plus one
// - Capture, counter, status readable anytime
//
// Added by the designer: the register offsets and the APB interface to the registers.
module pulse_capture import capture_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic timer_input_pin,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic channel_interrupt
);
  typedef struct packed {
    logic power;
    logic [2:0] mode;
    logic enable;
    chan_state_t st;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic ovf;
    logic wrapped;
    logic irq;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } cap_t;
  cap_t r_r, r_nxt;
  edge_if pin_e();
  logic wr, err_c;
  logic [31:0] rdata_c;
  logic start_hit, stop_hit, start_edge, cap_edge, width_mode;
  logic ena;
  logic [1:0] edge_sel;

  assign ena = clk_en & r_r.power;

  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ena),
    .clr(~r_r.power),
    .pin(timer_input_pin),
    .e(pin_e)
  );

  apb_regs u_regs (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .ctl_q({31'h0, r_r.power}),
    .mode_q({29'h0, r_r.mode}),
    .stat_q({31'h0, r_r.ovf}),
    .cnt_q({16'h0, r_r.cnt}),
    .cap_q({16'h0, r_r.cap}),
    .en_q({31'h0, r_r.enable}),
    .wr(wr),
    .rdata(rdata_c),
    .err(err_c)
  );

  assign width_mode = r_r.mode[bit_width_mode];
  assign edge_sel = r_r.mode[bit_cis_hi:bit_cis_lo];
  assign start_hit = wr & (paddr == addr_trigger) & pwdata[bit_start];
  assign stop_hit = wr & (paddr == addr_trigger) & pwdata[bit_stop];
  // Edge select picks which pin edge opens and closes a width
  always_comb begin
    start_edge = 1'b0;
    cap_edge = 1'b0;
    case (edge_sel)
      cis_high: begin
        start_edge = pin_e.rise;
        cap_edge = pin_e.fall;
      end
      cis_low: begin
        start_edge = pin_e.fall;
        cap_edge = pin_e.rise;
      end
      default: begin
        cap_edge = pin_e.rise;
      end
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.irq = 1'b0;
    r_nxt.rdy = 1'b0;
    r_nxt.err = 1'b0;
    if (psel & ~penable) begin
      r_nxt.rdy = 1'b1;
      r_nxt.rdata = rdata_c;
      r_nxt.err = err_c;
    end
    if (clk_en) begin
      if (wr & (paddr == addr_control)) begin
        r_nxt.power = pwdata[bit_power];
      end
      if (ena) begin
        if (wr & (paddr == addr_mode)) begin
          if (r_r.enable) begin
            r_nxt.mode[bit_cis_hi:bit_cis_lo] =
              pwdata[bit_cis_hi:bit_cis_lo];
          end else begin
            r_nxt.mode = pwdata[bit_width_mode:bit_cis_lo];
          end
        end
        case (r_r.st)
          st_idle: begin
            if (start_hit) begin
              r_nxt.enable = 1'b1;
              if (width_mode) begin
                r_nxt.st = st_wait;
              end else begin
                r_nxt.st = st_count;
                r_nxt.cnt = count_zero;
                r_nxt.wrapped = 1'b0;
              end
            end
          end
          st_wait: begin
            // Start edge seen on the synchronised pin restarts from zero
            if (start_edge) begin
              r_nxt.st = st_count;
              r_nxt.cnt = count_zero;
              r_nxt.wrapped = 1'b0;
            end
          end
          st_count: begin
            r_nxt.cnt = r_r.cnt + count_one;
            if (r_r.cnt == count_full) begin
              r_nxt.wrapped = 1'b1;
            end
            if (width_mode) begin
              if (cap_edge) begin
                r_nxt.cap = r_r.cnt;
                r_nxt.irq = 1'b1;
                r_nxt.ovf = r_r.wrapped | (r_r.cnt == count_full);
                r_nxt.st = st_wait;
              end
            end else if (cap_edge | start_hit) begin
              r_nxt.cap = r_r.cnt;
              r_nxt.cnt = count_zero;
              r_nxt.irq = 1'b1;
              r_nxt.ovf = r_r.wrapped | (r_r.cnt == count_full);
              r_nxt.wrapped = 1'b0;
            end
          end
          default: r_nxt.st = st_idle;
        endcase
        // Start while running in width mode is dropped here
        if (stop_hit) begin
          r_nxt.enable = 1'b0;
          r_nxt.st = st_idle;
          r_nxt.cnt = r_r.cnt;
          // A capture racing the stop is dropped whole, flag included
          r_nxt.cap = r_r.cap;
          r_nxt.ovf = r_r.ovf;
          r_nxt.irq = 1'b0;
        end
      end
      if (~r_r.power) begin
        r_nxt.mode = mode_reset;
        r_nxt.enable = 1'b0;
        r_nxt.st = st_idle;
        r_nxt.cnt = count_zero;
        r_nxt.cap = count_zero;
        r_nxt.ovf = 1'b0;
        r_nxt.wrapped = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata = r_r.rdata;
  assign pready = r_r.rdy;
  assign pslverr = r_r.err;
  assign channel_interrupt = r_r.irq;

  stop_holds_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && stop_hit |=> !r_r.enable && $stable(r_r.ovf))
    else $error("stop did not hold state");
  start_ignored_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.enable && width_mode && r_r.st == st_count
    && start_hit && !stop_hit && !cap_edge
    |=> r_r.st == st_count && r_r.cnt == $past(r_r.cnt) + count_one)
    else $error("start not ignored");
  capture_halt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    r_r.st == st_wait && clk_en && r_r.power && !start_edge && !stop_hit
    |=> r_r.cnt == $past(r_r.cnt))
    else $error("counter moved while waiting");
  cap_irq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(r_r.cap) && $past(r_r.power) |-> r_r.irq)
    else $error("capture without interrupt");
  cap_plus_one_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    r_r.irq && width_mode && r_r.st == st_wait
    |-> r_r.cnt == r_r.cap + count_one)
    else $error("counter not capture plus one");
  power_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !r_r.power |=> r_r.cnt == count_zero && !r_r.enable)
    else $error("power off did not reset");
  start_sets_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.st == st_idle && start_hit && !stop_hit
    |=> r_r.enable)
    else $error("start did not enable");
  count_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.st == st_wait && start_edge && !stop_hit
    |=> r_r.cnt == count_zero ##1 (!$past(clk_en) || r_r.cnt != count_zero
    || r_r.st != st_count))
    else $error("start edge did not begin at zero");
  ivl_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && !width_mode && r_r.st == st_count
    && (cap_edge || start_hit) && !stop_hit
    |=> r_r.cnt == count_zero && r_r.irq)
    else $error("interval capture did not clear");
  ivl_ovf_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && !width_mode && r_r.st == st_count
    && (cap_edge || start_hit) && !stop_hit
    && !r_r.wrapped && r_r.cnt != count_full |=> !r_r.ovf)
    else $error("overflow flag not cleared");
  stop_keeps_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && stop_hit
    |=> r_r.cnt == $past(r_r.cnt) && r_r.st == st_idle)
    else $error("stop changed the count");
  width_count_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && width_mode && r_r.st == st_count && !stop_hit
    |=> r_r.cnt == $past(r_r.cnt) + count_one)
    else $error("width counter did not count up");
  high_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.st == st_wait && edge_sel == cis_high
    && pin_e.rise && !stop_hit |=> r_r.st == st_count)
    else $error("rising edge did not start high width");
  low_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.st == st_wait && edge_sel == cis_low
    && pin_e.fall && !stop_hit |=> r_r.st == st_count)
    else $error("falling edge did not start low width");
  high_cap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && width_mode && r_r.st == st_count
    && edge_sel == cis_high && pin_e.fall && !stop_hit
    |=> r_r.irq && r_r.st == st_wait)
    else $error("falling edge did not capture high width");
  low_cap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && width_mode && r_r.st == st_count
    && edge_sel == cis_low && pin_e.rise && !stop_hit
    |=> r_r.irq && r_r.st == st_wait)
    else $error("rising edge did not capture low width");
  wait_no_cap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.st == st_wait
    |=> $stable(r_r.cap) && !r_r.irq)
    else $error("capture while waiting for start");
  power_clears_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !r_r.power
    |=> r_r.cap == count_zero && !r_r.ovf && r_r.mode == mode_reset)
    else $error("power off left state behind");
  wrap_ovf_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && width_mode && r_r.st == st_count && r_r.wrapped
    && cap_edge && !stop_hit |=> r_r.ovf)
    else $error("wrapped width without overflow flag");
  mode_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && r_r.power && r_r.enable && wr && paddr == addr_mode
    |=> r_r.mode[bit_width_mode] == $past(r_r.mode[bit_width_mode]))
    else $error("mode changed while running");
endmodule // pulse_capture

// ==== shared/capture_pkg.sv ====
// Package: register map, fields, modes and states of the capture channel.
// Assumes a 32-bit APB slave with word-aligned registers.
package capture_pkg;
  localparam logic [11:0] addr_control = 12'h000;
  localparam logic [11:0] addr_mode = 12'h004;
  localparam logic [11:0] addr_trigger = 12'h008;
  localparam logic [11:0] addr_status = 12'h00c;
  localparam logic [11:0] addr_counter = 12'h010;
  localparam logic [11:0] addr_capture = 12'h014;
  localparam logic [11:0] addr_enable = 12'h018;
  localparam int bit_power = 0;
  localparam int bit_start = 0;
  localparam int bit_stop = 1;
  localparam int bit_ovf = 0;
  localparam int bit_width_mode = 2;
  localparam int bit_cis_lo = 0;
  localparam int bit_cis_hi = 1;
  localparam logic [15:0] count_zero = 16'h0000;
  localparam logic [15:0] count_one = 16'h0001;
  localparam logic [15:0] count_full = 16'hffff;
  localparam logic [2:0] mode_reset = 3'h0;
  localparam logic [1:0] cis_low = 2'h2;
  localparam logic [1:0] cis_high = 2'h3;
  typedef enum logic [1:0] {st_idle, st_wait, st_count} chan_state_t;
endpackage

// ==== shared/edge_if.sv ====
// Interface: synchronised pin level and its edge pulses.
// Assumes one clock domain shared by producer and consumer.
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ==== testbench/pulse_src.sv ====
// Pulse source model for the timer input pin.
// Assumes the bench calls its tasks; the pin moves just after pclk edges.
module pulse_src (
  input wire logic pclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Push-pull source: it always holds a level, so no float to model
  initial pin = 1'b0;
  task level(input logic v);
    @(posedge pclk);
    pin <= v;
  endtask
  task pulse(input logic lvl, input int n);
    level(lvl);
    repeat (n) @(posedge pclk);
    pin <= !lvl;
  endtask
endmodule // pulse_src

// ==== testbench/test_input_pulse_width_capture.sv ====
// Self-checking bench for the pulse width capture channel.
// Assumes pulse_src drives the pin and pclk runs at 25 MHz.
module test_input_pulse_width_capture import capture_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, channel_interrupt, pin, e;
  logic ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, cap, held;
  logic [15:0] lfsr = 16'hd505;
  int errors = 0, checks = 0, irqs = 0, w, i, k;
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (channel_interrupt === 1'b1) irqs++;
  pulse_capture u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .timer_input_pin(pin), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .channel_interrupt(channel_interrupt));
  pulse_src u_src (.pclk(pclk), .pin(pin));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Master waits for pready; only the watchdog ends a hung wait
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  // Sampling may cost up to two clocks short, so allow exp-2 to exp
  task near(input int exp);
    apb(1'b0, addr_capture, 32'h0);
    cap = r;
    check({31'h0, (cap + 2 >= exp) && (cap <= exp)}, 32'h1);
  endtask
  task width(input logic lvl, input int n, input int exp);
    k = irqs;
    u_src.pulse(lvl, n);
    repeat (6) @(posedge pclk);
    check(32'(irqs - k), 32'h1);
    near(exp);
    rd(addr_counter, cap + 1);
  endtask
  task close_out();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h0fc, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, addr_control, 32'h1);
    apb(1'b1, addr_mode, 32'h7);
    apb(1'b1, addr_trigger, 32'h1);
    rd(addr_enable, 32'h1);
    rd(addr_trigger, 32'h0);
    repeat (20) @(posedge pclk);
    rd(addr_counter, 32'h0);
    apb(1'b1, addr_trigger, 32'h1);
    for (i = 0; i < 4; i++) begin
      w = 4 + int'(rnd() & 16'h003f);
      width(1'b1, w, w);
      rd(addr_status, 32'h0);
    end
    width(1'b1, 65546, 10);
    rd(addr_status, 32'h1);
    fork
      u_src.pulse(1'b1, 100);
      begin
        repeat (20) @(posedge pclk);
        apb(1'b1, addr_trigger, 32'h1);
        repeat (17) @(posedge pclk);
        apb(1'b1, addr_trigger, 32'h2);
      end
    join
    rd(addr_enable, 32'h0);
    apb(1'b0, addr_counter, 32'h0);
    held = r;
    repeat (10) @(posedge pclk);
    rd(addr_counter, held);
    rd(addr_status, 32'h1);
    apb(1'b1, addr_mode, 32'h6);
    u_src.level(1'b1);
    apb(1'b1, addr_trigger, 32'h1);
    for (i = 0; i < 2; i++) begin
      w = 4 + int'(rnd() & 16'h001f);
      width(1'b0, w, w);
    end
    rd(addr_status, 32'h0);
    apb(1'b1, addr_trigger, 32'h2);
    apb(1'b1, addr_mode, 32'h0);
    u_src.level(1'b0);
    apb(1'b1, addr_trigger, 32'h1);
    w = 20 + int'(rnd() & 16'h001f);
    k = irqs;
    for (i = 0; i < 2; i++) begin
      u_src.pulse(1'b1, 3);
      repeat (w - 4) @(posedge pclk);
    end
    check(32'(irqs - k), 32'h2);
    near(w);
    rd(addr_status, 32'h0);
    k = irqs;
    apb(1'b1, addr_trigger, 32'h1);
    repeat (4) @(posedge pclk);
    check(32'(irqs - k), 32'h1);
    // Ten frozen edges: only the four live ones may advance the count
    apb(1'b0, addr_counter, 32'h0);
    held = r;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (10) @(posedge pclk);
    ce <= 1'b1;
    rd(addr_counter, held + 4);
    apb(1'b1, addr_control, 32'h0);
    rd(addr_counter, 32'h0);
    rd(addr_capture, 32'h0);
    rd(addr_enable, 32'h0);
    close_out();
  end
endmodule // test_input_pulse_width_capture
